/* hw/fch_pkg.sv */
package fch_pkg;
  // ==========================================================
  // apb register byte offsets
  localparam logic [7:0] OFS_CMD     = 8'h00; // fid, set/get, go
  localparam logic [7:0] OFS_CDW11   = 8'h04; // command dword 11
  localparam logic [7:0] OFS_NSID    = 8'h08; // namespace id
  localparam logic [7:0] OFS_CDW0    = 8'h0c; // completion dword 0
  localparam logic [7:0] OFS_STAT    = 8'h10; // status code, busy
  localparam logic [7:0] OFS_BUF_IDX = 8'h14; // buffer dword index
  localparam logic [7:0] OFS_BUF_DAT = 8'h18; // buffer data port
  localparam logic [7:0] OFS_IRQ_ST  = 8'h1c; // sticky events, w1c
  localparam logic [7:0] OFS_IRQ_MSK = 8'h20; // event mask
  localparam logic [7:0] OFS_APST    = 8'h24; // autonomous enable
  // ==========================================================
  // command register fields
  localparam int CMD_SET_BIT = 8;
  localparam int CMD_GO_BIT  = 9;
  // feature identifiers
  localparam logic [7:0] FID_ARB   = 8'h01;
  localparam logic [7:0] FID_POWER = 8'h02;
  localparam logic [7:0] FID_RANGE = 8'h03;
  // status codes
  localparam logic [7:0] SC_OK        = 8'h00;
  localparam logic [7:0] SC_INV_FIELD = 8'h02;
  localparam logic [31:0] NSID_BCAST  = 32'hffffffff;
  // burst value meaning no limit
  localparam logic [2:0] BURST_NOLIM = 3'h7;
  // range table: 4096 bytes = 1024 dwords, 64 entries of 16
  localparam int BUF_WORDS = 1024;
  localparam int IDX_W     = 10;
  // irq bits
  localparam int EV_DONE = 0;
  localparam int EV_ERR  = 1;
  // reset values
  localparam logic [7:0] WEIGHT_RST = 8'h00;
  localparam logic [2:0] BURST_RST  = 3'h0;
  localparam logic [4:0] PS_RST     = 5'h00;
  localparam logic [5:0] RCNT_RST   = 6'h00;
  // ==========================================================
  typedef enum logic [1:0] {
    FCH_IDLE = 2'b00,
    FCH_EXEC = 2'b01,
    FCH_CPLT = 2'b11
  } fch_state_t;
endpackage

/* hw/fch_launch_limit.sv */
// ============================================================
// burst field to per-queue launch limit
module fch_launch_limit (
  input  wire logic [2:0] queue_launch_burst, // burst exponent
  output logic      [7:0] launch_limit,       // commands per launch
  output logic            launch_unlimited    // no limit applies
);
  // two to the power of the field, 111b means unlimited
  always_comb
  begin
    launch_unlimited = (queue_launch_burst == fch_pkg::BURST_NOLIM);
    launch_limit     = 8'h01 << queue_launch_burst;
  end
endmodule

/* hw/fch_feature_handler.sv */
// How it works
// - Feature 01h set takes arbitration parameters from dword 11.
// - Get of arbitration returns stored fields in completion dword 0.
// - Bits 31:24 hold zero-based high class weight.
// - Bits 23:16 hold zero-based medium class weight.
// - Bits 15:08 hold zero-based low class weight.
// - Launch limit is two to burst field; 111b means unlimited.
// - Successful power set leaves device in requested state.
// - Unsupported power state aborts with invalid field status.
// - Workload hint bits 07:05 stored and returned on get.
// - Power get returns current or target state in bits 04:00.
// - Autonomous transitions continue from the newly set state.
// - Range data from latest successful set replaces earlier data.
// - Range set with broadcast namespace aborts, invalid field.
// - Range table is 4096 bytes in one contiguous buffer.
// - Range get returns count in dword 0 and table in buffer.
// - Set range count is bits 05:00, ignored on get.
// - Range get puts zero-based valid range count in bits 05:00.
// - Table holds at most 64 entries of 64 bytes.
module fch_feature_handler (
  input  wire logic        pclk,                  // controller clock
  input  wire logic        presetn,               // async reset, low
  input  wire logic        psel,                  // apb select
  input  wire logic        penable,               // apb access phase
  input  wire logic        pwrite,                // apb direction
  input  wire logic [7:0]  paddr,                 // apb byte address
  input  wire logic [31:0] pwdata,                // apb write data
  output logic      [31:0] prdata,                // apb read data
  output logic             pready,                // apb ready
  output logic             pslverr,               // apb error
  input  wire logic [4:0]  supported_state_count, // zero-based count
  input  wire logic        auto_req,              // autonomous request
  input  wire logic [4:0]  auto_state,            // autonomous target
  output logic      [7:0]  high_class_weight,     // high weight
  output logic      [7:0]  medium_class_weight,   // medium weight
  output logic      [7:0]  low_class_weight,      // low weight
  output logic      [7:0]  launch_limit,          // per-queue limit
  output logic             launch_unlimited,      // burst unlimited
  output logic      [4:0]  power_state_select,    // current state
  output logic      [2:0]  workload_hint,         // workload hint
  output logic      [5:0]  range_count,           // zero-based ranges
  output logic             irq                    // level interrupt
);
  // ==========================================================
  // storage
  fch_pkg::fch_state_t state_r;
  logic [7:0]  fid_r;
  logic        is_set_r;
  logic [31:0] cdw11_r;
  logic [31:0] nsid_r;
  logic [31:0] cdw0_r;
  logic [7:0]  sc_r;
  logic [9:0]  idx_r;
  logic [1:0]  irq_st_r;
  logic [1:0]  irq_msk_r;
  logic        apst_en_r;
  logic [7:0]  hw_r, mw_r, lw_r;
  logic [2:0]  burst_r;
  logic [4:0]  ps_r;
  logic [2:0]  hint_r;
  logic [5:0]  rcnt_r;
  logic        bank_r;
  logic [31:0] bank0 [fch_pkg::BUF_WORDS];
  logic [31:0] bank1 [fch_pkg::BUF_WORDS];
  logic [31:0] prdata_r;
  logic        pslverr_r;

  // ==========================================================
  // apb decode
  logic setup, acc_wr, acc_rd, exec, ok_cmd;
  logic [7:0] sc_nxt;
  logic [31:0] cdw0_nxt;
  logic [1:0]  ev;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a <= fch_pkg::OFS_APST) && (a[1:0] == 2'b00);
  endfunction

  assign setup   = psel && !penable;
  assign acc_wr  = psel && penable && pwrite;
  assign acc_rd  = psel && penable && !pwrite;
  assign exec    = (state_r == fch_pkg::FCH_EXEC);
  assign pready  = 1'b1;
  assign prdata  = prdata_r;
  assign pslverr = pslverr_r;

  // read data and error captured in setup, shown in access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r  <= 32'h00000000;
      pslverr_r <= 1'b0;
    end
    else if (setup)
    begin
      pslverr_r <= !mapped(paddr);
      if (pwrite)
        prdata_r <= 32'h00000000;
      else if (paddr == fch_pkg::OFS_CMD)
        prdata_r <= {23'h0, is_set_r, fid_r};
      else if (paddr == fch_pkg::OFS_CDW11)
        prdata_r <= cdw11_r;
      else if (paddr == fch_pkg::OFS_NSID)
        prdata_r <= nsid_r;
      else if (paddr == fch_pkg::OFS_CDW0)
        prdata_r <= cdw0_r;
      else if (paddr == fch_pkg::OFS_STAT)
        prdata_r <= {23'h0, state_r != fch_pkg::FCH_IDLE, sc_r};
      else if (paddr == fch_pkg::OFS_BUF_IDX)
        prdata_r <= {22'h0, idx_r};
      else if (paddr == fch_pkg::OFS_BUF_DAT) // active table
        prdata_r <= bank_r ? bank1[idx_r] : bank0[idx_r];
      else if (paddr == fch_pkg::OFS_IRQ_ST)
        prdata_r <= {30'h0, irq_st_r};
      else if (paddr == fch_pkg::OFS_IRQ_MSK)
        prdata_r <= {30'h0, irq_msk_r};
      else if (paddr == fch_pkg::OFS_APST)
        prdata_r <= {31'h0, apst_en_r};
      else
        prdata_r <= 32'h00000000;
    end
  end

  // ==========================================================
  // command registers; go is ignored while a command runs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fid_r    <= 8'h00;
      is_set_r <= 1'b0;
      cdw11_r  <= 32'h00000000;
      nsid_r   <= 32'h00000000;
    end
    else if (acc_wr && state_r == fch_pkg::FCH_IDLE)
    begin
      if (paddr == fch_pkg::OFS_CMD)
      begin
        fid_r    <= pwdata[7:0];
        is_set_r <= pwdata[fch_pkg::CMD_SET_BIT];
      end
      else if (paddr == fch_pkg::OFS_CDW11)
        cdw11_r <= pwdata;
      else if (paddr == fch_pkg::OFS_NSID)
        nsid_r <= pwdata;
    end
  end

  // command sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_r <= fch_pkg::FCH_IDLE;
    else
      case (state_r)
        fch_pkg::FCH_IDLE:
          if (acc_wr && paddr == fch_pkg::OFS_CMD
              && pwdata[fch_pkg::CMD_GO_BIT])
            state_r <= fch_pkg::FCH_EXEC;
        fch_pkg::FCH_EXEC:
          state_r <= fch_pkg::FCH_CPLT;
        default:
          state_r <= fch_pkg::FCH_IDLE;
      endcase
  end

  // ==========================================================
  // command validation and completion dword 0
  always_comb
  begin
    sc_nxt   = fch_pkg::SC_OK;
    cdw0_nxt = 32'h00000000;
    if (fid_r == fch_pkg::FID_ARB)
      cdw0_nxt = {hw_r, mw_r, lw_r, 5'h00, burst_r};
    else if (fid_r == fch_pkg::FID_POWER)
    begin
      if (is_set_r && cdw11_r[4:0] > supported_state_count)
        sc_nxt = fch_pkg::SC_INV_FIELD;
      cdw0_nxt = {24'h0, hint_r, ps_r};
    end
    else if (fid_r == fch_pkg::FID_RANGE)
    begin
      if (is_set_r && nsid_r == fch_pkg::NSID_BCAST)
        sc_nxt = fch_pkg::SC_INV_FIELD;
      cdw0_nxt = {26'h0, rcnt_r};
    end
    else
      sc_nxt = fch_pkg::SC_INV_FIELD;
    if (is_set_r)
      cdw0_nxt = 32'h00000000;
  end
  assign ok_cmd = exec && is_set_r && (sc_nxt == fch_pkg::SC_OK);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cdw0_r <= 32'h00000000;
      sc_r   <= fch_pkg::SC_OK;
    end
    else if (exec)
    begin
      cdw0_r <= cdw0_nxt;
      sc_r   <= sc_nxt;
    end
  end

  // ==========================================================
  // arbitration setting; reserved bits 07:03 ignored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hw_r    <= fch_pkg::WEIGHT_RST;
      mw_r    <= fch_pkg::WEIGHT_RST;
      lw_r    <= fch_pkg::WEIGHT_RST;
      burst_r <= fch_pkg::BURST_RST;
    end
    else if (ok_cmd && fid_r == fch_pkg::FID_ARB)
    begin
      hw_r    <= cdw11_r[31:24];
      mw_r    <= cdw11_r[23:16];
      lw_r    <= cdw11_r[15:8];
      burst_r <= cdw11_r[2:0];
    end
  end

  // power state: set wins, then autonomous moves from there
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ps_r   <= fch_pkg::PS_RST;
      hint_r <= 3'h0;
    end
    else if (ok_cmd && fid_r == fch_pkg::FID_POWER)
    begin
      ps_r   <= cdw11_r[4:0];
      hint_r <= cdw11_r[7:5];
    end
    else if (apst_en_r && auto_req
             && auto_state <= supported_state_count)
      ps_r <= auto_state;
  end

  // range count and table bank swap on successful set
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rcnt_r <= fch_pkg::RCNT_RST;
      bank_r <= 1'b0;
    end
    else if (ok_cmd && fid_r == fch_pkg::FID_RANGE)
    begin
      rcnt_r <= cdw11_r[5:0];
      bank_r <= !bank_r;
    end
  end

  // host fills the staging bank, 4096 bytes, one index space
  always_ff @(posedge pclk)
  begin
    if (acc_wr && paddr == fch_pkg::OFS_BUF_DAT)
    begin
      if (bank_r)
        bank0[idx_r] <= pwdata;
      else
        bank1[idx_r] <= pwdata;
    end
  end

  // buffer index, auto-increments after each data access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      idx_r <= 10'h000;
    else if (acc_wr && paddr == fch_pkg::OFS_BUF_IDX)
      idx_r <= pwdata[fch_pkg::IDX_W-1:0];
    else if ((acc_wr || acc_rd) && paddr == fch_pkg::OFS_BUF_DAT)
      idx_r <= idx_r + 10'h001;
  end

  // ==========================================================
  // interrupts: set wins over a same-cycle clear
  assign ev = {exec && sc_nxt != fch_pkg::SC_OK, exec};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_st_r  <= 2'h0;
      irq_msk_r <= 2'h0;
      apst_en_r <= 1'b0;
    end
    else
    begin
      if (acc_wr && paddr == fch_pkg::OFS_IRQ_ST)
        irq_st_r <= (irq_st_r & ~pwdata[1:0]) | ev;
      else
        irq_st_r <= irq_st_r | ev;
      if (acc_wr && paddr == fch_pkg::OFS_IRQ_MSK)
        irq_msk_r <= pwdata[1:0];
      if (acc_wr && paddr == fch_pkg::OFS_APST)
        apst_en_r <= pwdata[0];
    end
  end
  assign irq = |(irq_st_r & irq_msk_r);

  // ==========================================================
  // outputs
  assign high_class_weight   = hw_r;
  assign medium_class_weight = mw_r;
  assign low_class_weight    = lw_r;
  assign power_state_select  = ps_r;
  assign workload_hint       = hint_r;
  assign range_count         = rcnt_r;

  fch_launch_limit u_lim (
    .queue_launch_burst (burst_r),
    .launch_limit       (launch_limit),
    .launch_unlimited   (launch_unlimited)
  );

  // ==========================================================
  // checks
  sequence set_of(logic [7:0] f);
    exec && is_set_r && fid_r == f;
  endsequence

  arb_weight_a: assert property (@(posedge pclk) disable iff (!presetn)
    set_of(fch_pkg::FID_ARB) |=> high_class_weight == $past(cdw11_r[31:24])
      && medium_class_weight == $past(cdw11_r[23:16])
      && low_class_weight == $past(cdw11_r[15:8]))
    else $error("arbitration weights not taken");
  arb_get_a: assert property (@(posedge pclk) disable iff (!presetn)
    exec && !is_set_r && fid_r == fch_pkg::FID_ARB
      |=> cdw0_r == {hw_r, mw_r, lw_r, 5'h00, burst_r})
    else $error("arbitration get mismatch");
  burst_lim_a: assert property (@(posedge pclk) disable iff (!presetn)
    launch_unlimited == (burst_r == 3'h7)
      && (burst_r == 3'h7 || launch_limit == (8'h01 << burst_r)))
    else $error("launch limit wrong");
  ps_apply_a: assert property (@(posedge pclk) disable iff (!presetn)
    set_of(fch_pkg::FID_POWER) ##0 cdw11_r[4:0] <= supported_state_count
      |=> power_state_select == $past(cdw11_r[4:0])
        && workload_hint == $past(cdw11_r[7:5]))
    else $error("power state not applied");
  ps_reject_a: assert property (@(posedge pclk) disable iff (!presetn)
    set_of(fch_pkg::FID_POWER) ##0 cdw11_r[4:0] > supported_state_count
      |=> sc_r == 8'h02 && irq_st_r[1] && $stable(workload_hint))
    else $error("bad power state accepted");
  ps_get_a: assert property (@(posedge pclk) disable iff (!presetn)
    exec && !is_set_r && fid_r == fch_pkg::FID_POWER
      |=> cdw0_r[31:8] == 24'h0 && cdw0_r[4:0] == $past(ps_r))
    else $error("power get mismatch");
  auto_move_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ok_cmd && apst_en_r && auto_req && auto_state <= supported_state_count
      |=> power_state_select == $past(auto_state))
    else $error("autonomous move lost");
  bank_swap_a: assert property (@(posedge pclk) disable iff (!presetn)
    set_of(fch_pkg::FID_RANGE) ##0 nsid_r != 32'hffffffff
      |=> bank_r != $past(bank_r) && range_count == $past(cdw11_r[5:0]))
    else $error("range set not retained");
  bcast_a: assert property (@(posedge pclk) disable iff (!presetn)
    set_of(fch_pkg::FID_RANGE) ##0 nsid_r == 32'hffffffff
      |=> sc_r == 8'h02 && $stable(bank_r) ##1 state_r == fch_pkg::FCH_IDLE)
    else $error("broadcast range set not aborted");
  rng_get_a: assert property (@(posedge pclk) disable iff (!presetn)
    exec && !is_set_r && fid_r == fch_pkg::FID_RANGE
      |=> cdw0_r == {26'h0, range_count} && $stable(range_count))
    else $error("range get count wrong");
  irq_lvl_a: assert property (@(posedge pclk) disable iff (!presetn)
    exec |=> irq_st_r[0] && (!irq_msk_r[0] || irq))
    else $error("done interrupt missing");
endmodule

/* test/fch_host_model.sv */
// ============================================================
// host side: apb master issuing register transfers
module fch_host_model (
  input  wire logic        pclk,    // controller clock
  input  wire logic        pready,  // apb ready
  input  wire logic        pslverr, // apb error
  input  wire logic [31:0] prdata,  // apb read data
  output logic             psel,    // apb select
  output logic             penable, // apb access phase
  output logic             pwrite,  // apb direction
  output logic      [7:0]  paddr,   // apb byte address
  output logic      [31:0] pwdata   // apb write data
);
  timeunit 1ns;
  timeprecision 1ps;
  // bus idle from time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // one transfer; request held until pready seen high
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for ready; only the bench watchdog ends a stuck wait
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

/* test/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        auto_req, irq, launch_unlimited;
  logic [7:0]  paddr, hw, mw, lw, launch_limit;
  logic [31:0] pwdata, prdata, q, r, m_arb;
  logic [4:0]  ssc, auto_state, pss;
  logic [2:0]  wh;
  logic [5:0]  rc, m_cnt;
  logic [7:0]  m_pwr;
  logic [1:0]  m_msk;
  logic        e;
  logic [31:0] act [1024];
  logic [31:0] stg [1024];
  int          err_total, n_tests;
  // ==========================================================
  // clock and instances
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  fch_host_model host (.pclk(pclk), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));
  fch_feature_handler dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .supported_state_count(ssc), .auto_req(auto_req),
    .auto_state(auto_state), .high_class_weight(hw),
    .medium_class_weight(mw), .low_class_weight(lw),
    .launch_limit(launch_limit), .launch_unlimited(launch_unlimited),
    .power_state_select(pss), .workload_hint(wh), .range_count(rc),
    .irq(irq));
  // ==========================================================
  // compares, bus helpers, verdict
  task automatic chk_rd(string nm, logic [31:0] x, logic [31:0] g);
    n_tests++;
    if (g !== x)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic chk_pin(string nm, logic [7:0] x, logic [7:0] g);
    chk_rd(nm, 32'(x), 32'(g));
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    host.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(logic [7:0] a);
    host.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task automatic setm(logic [1:0] m);
    m_msk = m;
    wr(fch_pkg::OFS_IRQ_MSK, 32'(m));
  endtask
  // issue one command, poll busy, check results and events
  task automatic do_cmd(logic [7:0] fid, logic set, logic [31:0] c11,
                        logic [31:0] ns, logic [7:0] sc, logic [31:0] c0);
    int n;
    logic [1:0] ev;
    ev = {sc != fch_pkg::SC_OK, 1'b1};
    wr(fch_pkg::OFS_CDW11, c11);
    wr(fch_pkg::OFS_NSID, ns);
    wr(fch_pkg::OFS_CMD, {22'h0, 1'b1, set, fid});
    n = 0;
    do
    begin
      rd(fch_pkg::OFS_STAT);
      n++;
    end
    while (q[8] !== 1'b0 && n < 50);
    chk_rd("status", {24'h0, sc}, q);
    rd(fch_pkg::OFS_CDW0);
    chk_rd("cdw0", c0, q);
    rd(fch_pkg::OFS_IRQ_ST);
    chk_rd("irq status", {30'h0, ev}, q);
    chk_pin("irq", 8'(|(ev & m_msk)), 8'(irq));
    wr(fch_pkg::OFS_IRQ_ST, 32'h3);
    rd(fch_pkg::OFS_IRQ_ST);
    chk_rd("irq cleared", 32'h0, q);
    chk_pin("irq", 8'h0, 8'(irq));
  endtask
  // staging fill: whole contiguous 4096-byte table, 64 entries
  task automatic fill();
    wr(fch_pkg::OFS_BUF_IDX, 32'h0);
    for (int i = 0; i < 1024; i++)
    begin
      stg[i] = $urandom;
      wr(fch_pkg::OFS_BUF_DAT, stg[i]);
    end
  endtask
  task automatic check_buf(int n);
    wr(fch_pkg::OFS_BUF_IDX, 32'h0);
    for (int i = 0; i < n; i++)
    begin
      rd(fch_pkg::OFS_BUF_DAT);
      chk_rd("buffer", act[i], q);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========================================================
  // watchdog: well beyond the expected 14k cycles
  initial
  begin
    #2500000;
    err_total++;
    print_verdict();
  end
  // ==========================================================
  // main sequence
  initial
  begin
    presetn = 1'b0;
    auto_req = 1'b0;
    auto_state = 5'h00;
    ssc = 5'h03;
    err_total = 0;
    n_tests = 0;
    m_pwr = 8'h00;
    m_cnt = 6'h00;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    void'($urandom(32'h48e4));
    chk_pin("limit at reset", 8'h01, launch_limit);
    chk_pin("weight at reset", 8'h00, hw);
    setm(2'h3);
    rd(8'h30);
    chk_rd("unmapped", 32'h0, q);
    chk_pin("slverr", 8'h01, 8'(e));
    // every burst code, random weights and reserved bits
    for (int b = 0; b < 8; b++)
    begin
      r = $urandom;
      r[2:0] = 3'(b);
      do_cmd(fch_pkg::FID_ARB, 1'b1, r, 32'h1, fch_pkg::SC_OK, 0);
      chk_pin("high", r[31:24], hw);
      chk_pin("medium", r[23:16], mw);
      chk_pin("low", r[15:8], lw);
      chk_pin("limit", 8'(1 << b), launch_limit);
      chk_pin("unlimited", 8'(b == 7), 8'(launch_unlimited));
      m_arb = r & 32'hffffff07;
      do_cmd(fch_pkg::FID_ARB, 1'b0, $urandom, 32'h1, fch_pkg::SC_OK,
             m_arb);
    end
    // power states 0..3 supported, 4 refused
    for (int p = 0; p < 5; p++)
    begin
      r = $urandom;
      r[4:0] = 5'(p);
      do_cmd(fch_pkg::FID_POWER, 1'b1, r, 32'h1,
             p < 4 ? fch_pkg::SC_OK : fch_pkg::SC_INV_FIELD, 0);
      if (p < 4)
        m_pwr = r[7:0];
      chk_pin("power state", 8'(m_pwr[4:0]), 8'(pss));
      chk_pin("hint", 8'(m_pwr[7:5]), 8'(wh));
      do_cmd(fch_pkg::FID_POWER, 1'b0, $urandom, 32'h1, fch_pkg::SC_OK,
             32'(m_pwr));
    end
    // autonomous move from the newly set state
    wr(fch_pkg::OFS_APST, 32'h1);
    @(posedge pclk);
    auto_req <= 1'b1;
    auto_state <= 5'h01;
    @(posedge pclk);
    auto_req <= 1'b0;
    for (int n = 0; n < 10 && pss !== 5'h01; n++) @(posedge pclk);
    m_pwr[4:0] = 5'h01;
    chk_pin("auto state", 8'h01, 8'(pss));
    // unsupported autonomous target must leave the state alone
    @(posedge pclk);
    auto_req <= 1'b1;
    auto_state <= 5'h1f;
    @(posedge pclk);
    auto_req <= 1'b0;
    repeat (2) @(posedge pclk);
    chk_pin("auto refused", 8'h01, 8'(pss));
    do_cmd(fch_pkg::FID_POWER, 1'b0, 0, 32'h1, fch_pkg::SC_OK,
           32'(m_pwr));
    // unknown feature with error-only mask, then mask off
    setm(2'h2);
    do_cmd(8'h05, 1'b1, 0, 32'h1, fch_pkg::SC_INV_FIELD, 0);
    setm(2'h0);
    do_cmd(fch_pkg::FID_ARB, 1'b0, 0, 32'h1, fch_pkg::SC_OK,
           m_arb);
    setm(2'h3);
    // range table: good set, broadcast refusal, later set replaces
    for (int k = 0; k < 3; k++)
    begin
      fill();
      r = $urandom;
      do_cmd(fch_pkg::FID_RANGE, 1'b1, r,
             k == 1 ? fch_pkg::NSID_BCAST : 32'h1,
             k == 1 ? fch_pkg::SC_INV_FIELD : fch_pkg::SC_OK, 0);
      if (k != 1)
      begin
        m_cnt = r[5:0];
        for (int i = 0; i < 1024; i++) act[i] = stg[i];
      end
      chk_pin("range count", 8'(m_cnt), 8'(rc));
      do_cmd(fch_pkg::FID_RANGE, 1'b0, $urandom, 32'h1, fch_pkg::SC_OK,
             32'(m_cnt));
      check_buf(k == 0 ? 1024 : 64);
    end
    print_verdict();
  end
endmodule
